//--- rtl/mod_ctl_cfg.svh
// Constants for the modulator power and mode control pair
`ifndef MOD_CTL_CFG_SVH
`define MOD_CTL_CFG_SVH
`define CLK_MHZ          40
`define LOSS_TIME_US     40
`define LOSS_CYCLES      (`LOSS_TIME_US * `CLK_MHZ)
`define MCLK_DIV         10
`define MCLK_HALF        5'h0A
`define MDATA_DIV        4
`define RECOVER_CYCLES   32
`define RECOVER_W        6
`define WORD_BITS        24
`define ATT_W            3
`define ATT_MAX          3'h6
`define MODE_W           3
`define APB_CTRL         12'h000
`define APB_STAT         12'h004
`define APB_MASK         12'h008
`define APB_WORD         12'h00C
`define APB_DECIM        12'h010
`define CTRL_MCLK_EN     0
`define CTRL_SYNC        1
`define CTRL_TEST_EN     2
`define CTRL_MODE_LSB    4
`define CTRL_ATT_LSB     8
`define DECIM_DEFAULT    16'h0100
`define EV_WORD          0
`define EV_FLAG          1
`define EV_W             2
`endif

//--- rtl/mod_ctl_pkg.sv
// Types shared by both ends of the modulator control link
package mod_ctl_pkg;
	typedef logic [2:0] mode_t;
	typedef logic [2:0] att_t;
	typedef enum logic [1:0] {
		PWR_DOWN  = 2'b00,
		PWR_SLEEP = 2'b01,
		PWR_RUN   = 2'b10
	} power_t;
endpackage

//--- rtl/mod_link_if.sv
// Pin-level link between modulator device and its companion filter
`timescale 1ns/1ps
interface mod_link_if;
	logic       mclk;           // Master clock pin
	logic       msync;          // Sync pin
	logic [2:0] mode_sel;       // Mode select pins
	logic [2:0] attenuation_select;
	logic       tdata;          // Test bitstream
	logic       mdata_o;        // Modulator stream, device drive
	logic       mdata_oe;
	logic       instability_flag_o;
	logic       instability_flag_oe;
	logic       mdata;          // Resolved wire levels
	logic       instability_flag;
	assign mdata = mdata_oe ? mdata_o : 1'b0;
	assign instability_flag = instability_flag_oe ? instability_flag_o : 1'b0;
	modport device (input mclk, msync, mode_sel, attenuation_select, tdata,
		output mdata_o, mdata_oe, instability_flag_o, instability_flag_oe);
	modport filter (output mclk, msync, mode_sel, attenuation_select, tdata,
		input mdata, instability_flag);
endinterface

//--- rtl/mod_device.sv
// Modulator device end: loss-of-clock, mode decode, stream, stability
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "mod_ctl_cfg.svh"
module mod_device
	import mod_ctl_pkg::*;
#(
	parameter int LOSS_CYCLES = `LOSS_CYCLES
) (
	input  wire logic     pclk,
	input  wire logic     presetn,
	mod_link_if.device    link,
	input  wire logic     analog_bit,
	input  wire logic     over_range,
	output logic          modulator_en,
	output logic          ac_test_en,
	output logic          dc_test_en,
	output logic          out_en,
	output logic          buf_en,
	output logic          fourth_order,
	output logic [6:0]    atten_gain,
	output power_t        power_state
);
	import mod_ctl_pkg::*;

	// Three-stage synchronisers for every pin from the filter
	logic [2:0] mclk_s;
	logic [2:0] sync_s;
	logic [2:0] tdata_s;
	logic [2:0] mode_s1, mode_s2, mode_s3;
	logic [2:0] att_s1, att_s2, att_s3;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mclk_s  <= 3'h0;
			sync_s  <= 3'h0;
			tdata_s <= 3'h0;
			mode_s1 <= 3'h0;
			mode_s2 <= 3'h0;
			mode_s3 <= 3'h0;
			att_s1  <= 3'h0;
			att_s2  <= 3'h0;
			att_s3  <= 3'h0;
		end else begin
			mclk_s  <= {mclk_s[1:0], link.mclk};
			sync_s  <= {sync_s[1:0], link.msync};
			tdata_s <= {tdata_s[1:0], link.tdata};
			mode_s1 <= link.mode_sel;
			mode_s2 <= mode_s1;
			mode_s3 <= mode_s2;
			att_s1  <= link.attenuation_select;
			att_s2  <= att_s1;
			att_s3  <= att_s2;
		end
	end

	// A pin level counts only once stages two and three agree
	logic mclk_lvl_reg, sync_lvl_reg, tdata_lvl_reg;
	logic mclk_prev_reg, sync_prev_reg;
	mode_t mode_reg;
	att_t  att_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mclk_lvl_reg  <= 1'b0;
			sync_lvl_reg  <= 1'b0;
			tdata_lvl_reg <= 1'b0;
			mclk_prev_reg <= 1'b0;
			sync_prev_reg <= 1'b0;
			mode_reg      <= 3'h0;
			att_reg       <= 3'h0;
		end else begin
			if (mclk_s[1] == mclk_s[2]) mclk_lvl_reg <= mclk_s[2];
			if (sync_s[1] == sync_s[2]) sync_lvl_reg <= sync_s[2];
			if (tdata_s[1] == tdata_s[2]) tdata_lvl_reg <= tdata_s[2];
			if (mode_s2 == mode_s3) mode_reg <= mode_s3;
			if (att_s2 == att_s3) att_reg <= att_s3;
			mclk_prev_reg <= mclk_lvl_reg;
			sync_prev_reg <= sync_lvl_reg;
		end
	end

	wire mclk_rise = mclk_lvl_reg & ~mclk_prev_reg;
	wire mclk_edge = mclk_lvl_reg ^ mclk_prev_reg;
	wire sync_rise = sync_lvl_reg & ~sync_prev_reg;

	// Loss-of-clock timer runs on pclk, never on the master clock
	logic [31:0] loss_cnt_reg;
	logic        clk_ok_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loss_cnt_reg <= 32'h0;
			clk_ok_reg   <= 1'b0;          // Filter reset leaves clock off
		end else if (mclk_edge) begin
			loss_cnt_reg <= 32'h0;
			clk_ok_reg   <= 1'b1;          // Edges back: leave power down
		end else if (loss_cnt_reg >= 32'(LOSS_CYCLES - 1)) begin
			clk_ok_reg   <= 1'b0;          // Independent of mode pins
		end else begin
			loss_cnt_reg <= loss_cnt_reg + 32'h1;
		end
	end

	// Mode decode from the binary pin code
	wire mode_sleep = clk_ok_reg && (mode_reg == 3'h7);
	wire mod_on     = clk_ok_reg && !mode_sleep;
	wire ac_mode    = mod_on && (mode_reg == 3'h1 || mode_reg == 3'h2 ||
		mode_reg == 3'h3 || mode_reg == 3'h6);
	wire dc_mode    = mod_on && (mode_reg == 3'h4 || mode_reg == 3'h5);
	wire out_on     = (ac_mode && mode_reg != 3'h3) || dc_mode;
	wire buf_on     = (ac_mode && mode_reg != 3'h2) || dc_mode;
	wire [2:0] att_clip = (att_reg > `ATT_MAX) ? `ATT_MAX : att_reg;
	wire [6:0] gain_nx  = 7'h40 >> att_clip;

	// Conversion sequencer: one output bit every four master clock rising edges
	logic [1:0] phase_reg;
	logic       integ_reg;
	logic [5:0] calm_reg;
	logic       order4_reg;
	logic       flag_reg;
	logic       mdata_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_reg  <= 2'h0;
			integ_reg  <= 1'b0;
			calm_reg   <= 6'h0;
			order4_reg <= 1'b1;
			flag_reg   <= 1'b0;
			mdata_reg  <= 1'b0;
		end else if (!mod_on) begin
			phase_reg  <= 2'h0;
			mdata_reg  <= 1'b0;
		end else if (sync_rise) begin
			phase_reg  <= 2'h0;                // Align sample timing
			integ_reg  <= 1'b0;
		end else if (mclk_rise) begin
			phase_reg <= phase_reg + 2'h1;
			if (phase_reg == 2'(`MDATA_DIV - 1)) begin
				integ_reg <= integ_reg ^ analog_bit;
				mdata_reg <= integ_reg ^ analog_bit; // 500 kbit/s
			end
			if (over_range) begin
				order4_reg <= 1'b0;            // Collapse to first order
				flag_reg   <= 1'b1;
				calm_reg   <= 6'h0;
			end else if (!order4_reg) begin
				if (calm_reg == 6'(`RECOVER_CYCLES - 1)) begin
					order4_reg <= 1'b1;        // 32 calm cycles
					flag_reg   <= 1'b0;
				end else begin
					calm_reg <= calm_reg + 6'h1;
				end
			end
		end
	end

	// Registered outputs; stream and flag drivers released, reading low, whenever not running
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			modulator_en <= 1'b0;
			ac_test_en   <= 1'b0;
			dc_test_en   <= 1'b0;
			out_en       <= 1'b0;
			buf_en       <= 1'b0;
			fourth_order <= 1'b1;
			atten_gain   <= 7'h0;
			power_state  <= PWR_DOWN;
			link.mdata_o <= 1'b0;
			link.mdata_oe <= 1'b0;
			link.instability_flag_o  <= 1'b0;
			link.instability_flag_oe <= 1'b0;
		end else begin
			modulator_en <= mod_on;
			ac_test_en   <= ac_mode && tdata_lvl_reg | ac_mode;
			dc_test_en   <= dc_mode;
			out_en       <= out_on;
			buf_en       <= buf_on;
			fourth_order <= order4_reg;
			atten_gain   <= (ac_mode || dc_mode) ? gain_nx : 7'h0;
			power_state  <= !clk_ok_reg ? PWR_DOWN :
				mode_sleep ? PWR_SLEEP : PWR_RUN;
			link.mdata_o <= mdata_reg;
			link.mdata_oe <= mod_on;
			link.instability_flag_o  <= flag_reg;
			link.instability_flag_oe <= mod_on;
		end
	end
endmodule

//--- rtl/mod_filter.sv
// Companion filter end: clock, sync, pins, decimation, APB registers
`timescale 1ns/1ps
`include "mod_ctl_cfg.svh"
module mod_filter
	import mod_ctl_pkg::*;
#(
	parameter int DECIM_W = 16
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq,
	mod_link_if.filter       link
);
	import mod_ctl_pkg::*;

	// Control register: clock enable off after reset
	logic [31:0] ctrl_reg, mask_reg, word_reg;
	logic [DECIM_W-1:0] decim_reg;
	logic [`EV_W-1:0] stat_reg;
	wire acc   = psel & penable;
	wire wr    = acc & pwrite;
	wire rd    = acc & ~pwrite;
	wire hit_c = paddr == `APB_CTRL;
	wire hit_s = paddr == `APB_STAT;
	wire hit_m = paddr == `APB_MASK;
	wire hit_w = paddr == `APB_WORD;
	wire hit_d = paddr == `APB_DECIM;
	wire mapped = hit_c | hit_s | hit_m | hit_w | hit_d;
	wire [31:0] rd_mux = hit_c ? ctrl_reg : hit_s ? 32'(stat_reg) :
		hit_m ? mask_reg : hit_w ? word_reg :
		hit_d ? 32'(decim_reg) : 32'h0;

	// Master clock divider and sync pulse
	logic [4:0] div_reg;
	logic       mclk_reg, sync_reg;
	wire mclk_on = ctrl_reg[`CTRL_MCLK_EN];
	// Tick runs on after disable until the clock is low, keeping halves full
	wire mclk_tick = div_reg == 5'(`MCLK_HALF - 1);
	wire mclk_rise = mclk_tick && !mclk_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_reg  <= 5'h0;
			mclk_reg <= 1'b0;
		end else if (!mclk_on && !mclk_reg) begin
			div_reg  <= 5'h0;
		end else begin
			div_reg  <= mclk_tick ? 5'h0 : div_reg + 5'h1;
			if (mclk_tick) mclk_reg <= ~mclk_reg;
		end
	end

	// Sample the modulator stream through three stages
	logic [2:0] md_s, fl_s;
	logic md_lvl_reg, fl_lvl_reg, fl_prev_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			md_s <= 3'h0;
			fl_s <= 3'h0;
			md_lvl_reg <= 1'b0;
			fl_lvl_reg <= 1'b0;
			fl_prev_reg <= 1'b0;
		end else begin
			md_s <= {md_s[1:0], link.mdata};
			fl_s <= {fl_s[1:0], link.instability_flag};
			if (md_s[1] == md_s[2]) md_lvl_reg <= md_s[2];
			if (fl_s[1] == fl_s[2]) fl_lvl_reg <= fl_s[2];
			fl_prev_reg <= fl_lvl_reg;
		end
	end

	// Decimator: ones count per window into a 24-bit word
	logic [1:0]  bit_ph_reg;
	logic [DECIM_W-1:0] n_reg;
	logic [`WORD_BITS-1:0] acc_reg;
	logic word_ev;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bit_ph_reg <= 2'h0;
			n_reg   <= '0;
			acc_reg <= '0;
			word_reg <= 32'h0;
			word_ev <= 1'b0;
		end else begin
			word_ev <= 1'b0;
			if (mclk_rise) begin
				bit_ph_reg <= bit_ph_reg + 2'h1;
				if (bit_ph_reg == 2'(`MDATA_DIV - 1)) begin
					// Catches a window shortened while a longer one counts
					if (n_reg >= decim_reg - 1'b1) begin
						word_reg <= 32'(acc_reg + md_lvl_reg);
						acc_reg  <= '0;
						n_reg    <= '0;
						word_ev  <= 1'b1;
					end else begin
						acc_reg <= acc_reg + md_lvl_reg;
						n_reg   <= n_reg + 1'b1;
					end
				end
			end
		end
	end

	// Registers; a status read clears, but a new event wins
	wire [`EV_W-1:0] ev = {fl_lvl_reg & ~fl_prev_reg, word_ev};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg  <= 32'h0;
			mask_reg  <= 32'h0;
			decim_reg <= DECIM_W'(`DECIM_DEFAULT);
			stat_reg  <= '0;
		end else begin
			if (wr && hit_c) ctrl_reg <= pwdata;
			if (wr && hit_m) mask_reg <= pwdata;
			if (wr && hit_d) decim_reg <= pwdata[DECIM_W-1:0];
			// Clear only what the read reported; later events survive
			stat_reg <= ((rd && hit_s) ? (stat_reg & ~prdata[`EV_W-1:0]) :
				stat_reg) | ev;
		end
	end

	// Pin and bus outputs; mode and attenuation act as GPIO
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
			irq     <= 1'b0;
			sync_reg <= 1'b0;
			link.mclk  <= 1'b0;
			link.msync <= 1'b0;
			link.mode_sel <= 3'h0;
			link.attenuation_select <= 3'h0;
			link.tdata <= 1'b0;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~(paddr inside {`APB_CTRL,
				`APB_STAT, `APB_MASK, `APB_WORD, `APB_DECIM});
			prdata  <= (psel & ~penable & ~pwrite) ? rd_mux : prdata;
			irq     <= |(stat_reg & mask_reg[`EV_W-1:0]);
			sync_reg <= ctrl_reg[`CTRL_SYNC];
			link.mclk  <= mclk_reg;
			link.msync <= ctrl_reg[`CTRL_SYNC];
			link.mode_sel <= ctrl_reg[`CTRL_MODE_LSB +: `MODE_W];
			link.attenuation_select <= ctrl_reg[`CTRL_ATT_LSB +: `ATT_W];
			// Alternating pattern stays slow; caller must keep it small
			if (mclk_rise && ctrl_reg[`CTRL_TEST_EN])
				link.tdata <= ~link.tdata;
		end
	end
endmodule

//--- bench/mod_ctl_sva.sv
// Checker on the pins between the modulator device and its filter
`timescale 1ns/1ps
module mod_ctl_sva #(
	parameter int LOSS_CYCLES = 50
) (
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       mclk,
	input wire logic [2:0] mode_sel,
	input wire logic       mdata,
	input wire logic       mdata_oe,
	input wire logic       instability_flag_oe
);
	logic        mclk_q;
	logic [11:0] gap;
	logic [6:0]  run_cnt;
	logic [7:0]  since;
	logic        chg_seen;
	wire         mclk_chg = mclk != mclk_q;
	wire         dead = gap > 12'(LOSS_CYCLES + 12);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Gap starts saturated, since no clock edge is seen before reset ends
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mclk_q <= 1'b0;
			gap <= 12'hFFF;
			run_cnt <= 7'h00;
		end else begin
			mclk_q <= mclk;
			gap <= mclk_chg ? 12'h000 : gap + 12'(gap != 12'hFFF);
			if (gap < 12'h014 && mode_sel != 3'h7) begin
				run_cnt <= run_cnt + 7'(run_cnt != 7'h7F);
			end else begin
				run_cnt <= 7'h00;
			end
		end
	end
	// First change after enable may be short, so it only arms the check
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			since <= 8'h00;
			chg_seen <= 1'b0;
		end else begin
			since <= $changed(mdata) ? 8'h00 : since + 8'(since != 8'hFF);
			if (!mdata_oe) begin
				chg_seen <= 1'b0;
			end else if ($changed(mdata)) begin
				chg_seen <= 1'b1;
			end
		end
	end
	a_loss_mdata_off: assert property (dead |-> !mdata_oe)
		else $error("stream driven without clock");
	a_loss_flag_off: assert property (dead |-> !instability_flag_oe)
		else $error("flag driven without clock");
	a_sleep_mdata_off: assert property ((mode_sel == 3'h7) [*8] |-> !mdata_oe)
		else $error("stream driven in sleep");
	a_sleep_flag_off: assert property ((mode_sel == 3'h7) [*8] |-> !instability_flag_oe)
		else $error("flag driven in sleep");
	a_run_streams: assert property (run_cnt >= 7'd40 |-> mdata_oe)
		else $error("stream not driven while running");
	a_bit_period: assert property (chg_seen && mdata_oe && $past(mdata_oe)
		&& $changed(mdata) |-> since >= 8'd79)
		else $error("stream bit shorter than four clock periods");
	a_mclk_period: assert property (mclk_chg && gap < 12'h014 |-> gap == 12'd9)
		else $error("master clock half period wrong");
	a_mclk_half: assert property ($changed(mclk) |=> $stable(mclk) [*8])
		else $error("master clock toggled early");
endmodule

//--- bench/tb_modulator_dac_mode_power_control.sv
// Self-checking bench for the modulator device and filter pair
`timescale 1ns/1ps
`include "mod_ctl_cfg.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
	err_total++; $display("FAIL %s exp %0h got %0h", nm, e, g); end end
module tb_modulator_dac_mode_power_control;
	import mod_ctl_pkg::*;
	localparam int         LOSS = 50;
	localparam logic [7:0] MOD_M = 8'h7F;
	localparam logic [7:0] AC_M = 8'h4E;
	localparam logic [7:0] DC_M = 8'h30;
	localparam logic [7:0] OUT_M = 8'h46;
	localparam logic [7:0] BUF_M = 8'h4A;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic        analog_bit = 1'b0;
	logic        over_range = 1'b0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	logic        modulator_en;
	logic        ac_test_en;
	logic        dc_test_en;
	logic        out_en;
	logic        buf_en;
	logic        fourth_order;
	logic [6:0]  atten_gain;
	power_t      power_state;
	logic [31:0] q;
	logic        e;
	int          err_total = 0;
	int          check_count = 0;
	always #12.5 pclk = ~pclk;
	mod_link_if i_mod_link_if ();
	mod_device #(.LOSS_CYCLES(LOSS)) i_mod_device (.pclk(pclk),
		.presetn(presetn), .link(i_mod_link_if), .analog_bit(analog_bit),
		.over_range(over_range), .modulator_en(modulator_en),
		.ac_test_en(ac_test_en), .dc_test_en(dc_test_en), .out_en(out_en),
		.buf_en(buf_en), .fourth_order(fourth_order),
		.atten_gain(atten_gain), .power_state(power_state));
	mod_filter i_mod_filter (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.link(i_mod_link_if));
	mod_ctl_sva #(.LOSS_CYCLES(LOSS)) i_mod_ctl_sva (.pclk(pclk),
		.presetn(presetn), .mclk(i_mod_link_if.mclk),
		.mode_sel(i_mod_link_if.mode_sel), .mdata(i_mod_link_if.mdata),
		.mdata_oe(i_mod_link_if.mdata_oe),
		.instability_flag_oe(i_mod_link_if.instability_flag_oe));
	// One APB transfer; answer is taken in the access cycle, not assumed
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// Values read here are those sampled at this rising edge
		while (pready !== 1'b1 && n < 100) begin
			n++;
			@(posedge pclk);
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 100) err_total++;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge pclk);
	endtask
	function automatic logic [31:0] ctl(input logic [2:0] m,
		input logic [2:0] a);
		return 32'h5 | (32'(m) << 4) | (32'(a) << 8);
	endfunction
	task automatic t_reset();
		cyc(2);
		`CHK("state", PWR_DOWN, power_state)
		`CHK("oe", 1'b0, i_mod_link_if.mdata_oe)
		`CHK("irq", 1'b0, irq)
		apb(1'b0, `APB_CTRL, 32'h0);
		`CHK("ctrl", 32'h0, q)
		apb(1'b1, 12'h020, 32'hFFFF_FFFF);
		`CHK("werr", 1'b1, e)
		apb(1'b0, 12'h020, 32'h0);
		`CHK("rerr", 1'b1, e)
		`CHK("rzero", 32'h0, q)
	endtask
	// Every mode code, then every attenuation code in an AC mode
	task automatic t_modes();
		for (int m = 0; m < 8; m++) begin
			apb(1'b1, `APB_CTRL, ctl(m[2:0], 3'h0));
			cyc(200);
			`CHK("mod", MOD_M[m], modulator_en)
			`CHK("ac", AC_M[m], ac_test_en)
			`CHK("dc", DC_M[m], dc_test_en)
			if (!DC_M[m]) begin
				`CHK("out", OUT_M[m], out_en)
				`CHK("buf", BUF_M[m], buf_en)
			end
			`CHK("oe", MOD_M[m], i_mod_link_if.mdata_oe)
			`CHK("pwr", m == 7 ? PWR_SLEEP : PWR_RUN, power_state)
			if (m == 0) `CHK("gain0", 7'h00, atten_gain)
		end
		for (int a = 0; a < 8; a++) begin
			apb(1'b1, `APB_CTRL, ctl(3'h1, a[2:0]));
			cyc(200);
			`CHK("gain", 7'(64 >> (a > 6 ? 6 : a)), atten_gain)
		end
	endtask
	// Clock stops in an AC mode, then returns with another mode set
	task automatic t_loss();
		apb(1'b1, `APB_CTRL, ctl(3'h3, 3'h0) & ~32'h1);
		cyc(30);
		`CHK("early", PWR_RUN, power_state)
		cyc(40);
		`CHK("down", PWR_DOWN, power_state)
		`CHK("moddn", 1'b0, modulator_en)
		`CHK("flagoe", 1'b0, i_mod_link_if.instability_flag_oe)
		apb(1'b1, `APB_CTRL, ctl(3'h6, 3'h0));
		cyc(100);
		`CHK("back", PWR_RUN, power_state)
		`CHK("ac6", 1'b1, ac_test_en)
	endtask
	// Over-range with masked then unmasked interrupt, then recovery count
	task automatic t_instab();
		apb(1'b1, `APB_MASK, 32'h0);
		apb(1'b0, `APB_STAT, 32'h0);
		@(posedge pclk);
		over_range <= 1'b1;
		cyc(100);
		`CHK("first", 1'b0, fourth_order)
		`CHK("flag", 1'b1, i_mod_link_if.instability_flag)
		`CHK("masked", 1'b0, irq)
		apb(1'b1, `APB_MASK, 32'h2);
		cyc(2);
		`CHK("irq", 1'b1, irq)
		@(posedge pclk);
		over_range <= 1'b0;
		cyc(400);
		`CHK("hold", 1'b0, fourth_order)
		cyc(400);
		`CHK("fourth", 1'b1, fourth_order)
		apb(1'b0, `APB_STAT, 32'h0);
		`CHK("stat", 1'b1, q[`EV_FLAG])
		cyc(2);
		`CHK("irqclr", 1'b0, irq)
		apb(1'b0, `APB_STAT, 32'h0);
		`CHK("statclr", 1'b0, q[`EV_FLAG])
	endtask
	// Steady-high analog input decimated over a short window
	task automatic t_decim();
		apb(1'b1, `APB_DECIM, 32'h8);
		@(posedge pclk);
		analog_bit <= 1'b1;
		cyc(2000);
		apb(1'b0, `APB_STAT, 32'h0);
		for (int i = 0; i < 100 && !q[`EV_WORD]; i++) begin
			cyc(10);
			apb(1'b0, `APB_STAT, 32'h0);
		end
		`CHK("ready", 1'b1, q[`EV_WORD])
		apb(1'b0, `APB_WORD, 32'h0);
		// A steady high decision makes the stream alternate: half ones
		`CHK("word", 32'h4, q)
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// Watchdog well beyond the expected run of about six and a half thousand cycles
	initial begin
		repeat (40000) @(posedge pclk);
		err_total++;
		final_report();
	end
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_modes();
		t_loss();
		t_instab();
		t_decim();
		final_report();
	end
endmodule
